// >>> design/its_pkg.sv
// Constants, types and register map of the input terminal shutoff block.
// Operation
// - Each terminal has its own function code register.
// - Same code on several terminals ORs them.
// - Speed priority: jog, multi-speed, then PID.
// - Shutoff input covers unassigned run-enable or interlock.
// - Multi-speed and remote setting share the terminals.
// - V/F selection also selects the second set.
// - Control method frozen while running; second set only.
// - Analog select invalidates the voltage speed input.
// - Run-enable and shutoff act within 2 ms.
// - All other functions act within 20 ms.
// - Shutoff while running cuts output at once.
// - Shutoff function is terminal code 24.
// - Shutoff keeps output off despite start command.
// - Start removal decelerates; shutoff coasts instead.
// - Polarity setting: 0 default, also 2 and 4.
// - Setting 2 enables only when both inputs on.
// - Setting 4 ext on, comm off; 0 both off.
// - Shutoff acts in every operation mode.
// - Second-function input selects second parameter set.
// - Second-function input is terminal code 3.
package its_pkg;

  localparam int NUM_TERM = 5;
  localparam int CLK_HZ = 40_000_000;
  localparam int FAST_RESP_US = 2000;
  localparam int SLOW_RESP_US = 20000;
  localparam int FAST_RESP_CYC = FAST_RESP_US * (CLK_HZ / 1_000_000);
  localparam int SLOW_RESP_CYC = SLOW_RESP_US * (CLK_HZ / 1_000_000);
  // Contact filter uses half the slow budget, leaving margin for the rest.
  localparam int SLOW_FILTER_CYC = SLOW_RESP_CYC / 2;

  localparam logic [15:0] FN_SPEED_LOW = 16'h0000;
  localparam logic [15:0] FN_SPEED_MID = 16'h0001;
  localparam logic [15:0] FN_SPEED_HIGH = 16'h0002;
  localparam logic [15:0] FN_SECOND = 16'h0003;
  localparam logic [15:0] FN_ANALOG_SEL = 16'h0004;
  localparam logic [15:0] FN_JOG = 16'h0005;
  localparam logic [15:0] FN_SPEED_EXT = 16'h0008;
  localparam logic [15:0] FN_RUN_ENABLE = 16'h000a;
  localparam logic [15:0] FN_PANEL_IL = 16'h000c;
  localparam logic [15:0] FN_PID = 16'h000e;
  localparam logic [15:0] FN_CTRL_SW = 16'h0012;
  localparam logic [15:0] FN_SHUTOFF = 16'h0018;

  localparam logic [15:0] TERM_FN_RST [NUM_TERM] = '{
    16'h003c, 16'h003d, 16'h0000, 16'h0001, 16'h0002};

  localparam logic [2:0] POL_NO = 3'h0;
  localparam logic [2:0] POL_NC = 3'h2;
  localparam logic [2:0] POL_MIX = 3'h4;
  localparam logic [7:0] OPMODE_RST = 8'h00;
  localparam logic [7:0] OPMODE_INTERLOCK = 8'h07;

  localparam logic [7:0] OFF_TERM_FN = 8'h00;
  localparam logic [7:0] OFF_POLARITY = 8'h14;
  localparam logic [7:0] OFF_OPMODE = 8'h18;
  localparam logic [7:0] OFF_CONTROL = 8'h1c;
  localparam logic [7:0] OFF_STATUS = 8'h20;

  localparam int CTL_REMOTE = 0;
  localparam int CTL_COMM_SHUTOFF = 1;

  typedef enum logic [1:0] {
    SRC_ANALOG, SRC_PID, SRC_MULTI, SRC_JOG
  } its_speed_src_t;

  typedef enum logic [1:0] {
    DRV_STOP, DRV_RUN, DRV_DECEL, DRV_COAST
  } its_drive_t;

endpackage

// >>> design/its_term_filter.sv
// Two-stage synchroniser and contact filter for one input terminal.
`timescale 1ns/1ps
module its_term_filter #(
  parameter int FILTER_CYC = 400000
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pin,
  output logic sync_out,
  output logic filt_out
);
  localparam int CW = $clog2(FILTER_CYC + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(FILTER_CYC - 1);

  logic meta;
  logic [CW-1:0] cnt;
  wire differs = sync_out != filt_out;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta <= pin;
      sync_out <= meta;
    end
  end

  // A level must hold for the full window before it is accepted.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt <= '0;
      filt_out <= 1'b0;
    end else if (!differs) begin
      cnt <= '0;
    end else if (cnt == CNT_LAST) begin
      cnt <= '0;
      filt_out <= sync_out;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule

// >>> design/its_shutoff_logic.sv
// Input terminal function logic with output shutoff and AHB-Lite registers.
//
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module its_shutoff_logic
  import its_pkg::*;
#(
  parameter int SLOW_FILTER = SLOW_FILTER_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [NUM_TERM-1:0] term_in,
  input wire logic start_cmd,
  input wire logic motor_running,
  output logic output_on,
  output logic coast_out,
  output logic decel_out,
  output logic second_set_select,
  output logic vf_control,
  output logic voltage_input_valid,
  output its_speed_src_t speed_src,
  output logic [3:0] speed_index,
  output logic [2:0] remote_cmd,
  output logic run_enable_ok,
  output logic panel_interlock_in
);

  logic [15:0] term_fn [NUM_TERM];
  wire [NUM_TERM-1:0][15:0] fn_codes;
  logic [2:0] polarity;
  logic [7:0] opmode;
  logic [1:0] control;
  logic dp_wr;
  logic [7:0] dp_addr;
  logic [NUM_TERM-1:0] term_fast;
  logic [NUM_TERM-1:0] term_slow;
  its_drive_t drv;
  its_drive_t next_drv;

  // Terminal inputs: a fast synchronised copy and a filtered copy.
  genvar g;
  generate
    for (g = 0; g < NUM_TERM; g++) begin : g_term
      its_term_filter #(.FILTER_CYC(SLOW_FILTER)) u_filt (
        .clk(clk),
        .nrst(nrst),
        .pin(term_in[g]),
        .sync_out(term_fast[g]),
        .filt_out(term_slow[g])
      );
    end
  endgenerate

  // OR of every terminal whose function register holds the given code.
  // The codes are an argument so that a register write re-evaluates users.
  function automatic logic fn_on(input logic [NUM_TERM-1:0][15:0] fns,
                                 input logic [NUM_TERM-1:0] lv,
                                 input logic [15:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_TERM; i++) begin
      if (fns[i] == code && lv[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // AHB-Lite slave, zero wait states, always OKAY.
  wire ap_valid = hsel & htrans[1] & hready;
  wire ap_read = ap_valid & ~hwrite;
  wire [7:0] ap_addr = haddr[7:0];
  wire pol_legal = hwdata[2:0] == POL_NO || hwdata[2:0] == POL_NC ||
                   hwdata[2:0] == POL_MIX;
  wire wr_pol = dp_wr && dp_addr == OFF_POLARITY && hwdata[31:3] == '0;
  wire wr_opmode = dp_wr && dp_addr == OFF_OPMODE;
  wire wr_control = dp_wr && dp_addr == OFF_CONTROL;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dp_wr <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_wr <= ap_valid & hwrite;
      dp_addr <= ap_addr;
    end
  end

  generate
    for (g = 0; g < NUM_TERM; g++) begin : g_fnreg
      wire wr_fn = dp_wr && dp_addr == OFF_TERM_FN + 8'(4 * g);
      assign fn_codes[g] = term_fn[g];
      always_ff @(posedge clk) begin
        if (!nrst) begin
          term_fn[g] <= TERM_FN_RST[g];
        end else if (wr_fn) begin
          term_fn[g] <= hwdata[15:0];
        end
      end
    end
  endgenerate

  // Polarity writes outside the three legal values are ignored.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      polarity <= POL_NO;
      opmode <= OPMODE_RST;
      control <= 2'h0;
    end else begin
      if (wr_pol && pol_legal) begin
        polarity <= hwdata[2:0];
      end
      if (wr_opmode) begin
        opmode <= hwdata[7:0];
      end
      if (wr_control) begin
        control <= hwdata[1:0];
      end
    end
  end

  // Function decode. Shutoff and run enable use the fast path.
  wire ext_shutoff = fn_on(fn_codes, term_fast, FN_SHUTOFF);
  wire comm_shutoff = control[CTL_COMM_SHUTOFF];
  wire run_en_on = fn_on(fn_codes, term_fast, FN_RUN_ENABLE);
  wire run_en_asg = fn_on(fn_codes, '1, FN_RUN_ENABLE);
  wire panel_on = fn_on(fn_codes, term_slow, FN_PANEL_IL);
  wire panel_asg = fn_on(fn_codes, '1, FN_PANEL_IL);
  wire second_on = fn_on(fn_codes, term_slow, FN_SECOND);
  wire analog_on = fn_on(fn_codes, term_slow, FN_ANALOG_SEL);
  wire jog_on = fn_on(fn_codes, term_slow, FN_JOG);
  wire pid_on = fn_on(fn_codes, term_slow, FN_PID);
  wire ctrl_sw_on = fn_on(fn_codes, term_slow, FN_CTRL_SW);
  wire sp_low = fn_on(fn_codes, term_slow, FN_SPEED_LOW);
  wire sp_mid = fn_on(fn_codes, term_slow, FN_SPEED_MID);
  wire sp_high = fn_on(fn_codes, term_slow, FN_SPEED_HIGH);
  wire sp_ext = fn_on(fn_codes, term_slow, FN_SPEED_EXT);
  wire remote_mode = control[CTL_REMOTE];

  // Operation is enabled only for the one permitted input pair.
  wire op_enabled =
    (polarity == POL_NO && !ext_shutoff && !comm_shutoff) ||
    (polarity == POL_NC && ext_shutoff && comm_shutoff) ||
    (polarity == POL_MIX && ext_shutoff && !comm_shutoff);
  // Independent of operation mode by construction.
  wire shutoff_active = !op_enabled;

  // Unassigned run enable is covered by the shutoff gate itself.
  wire run_permit = run_en_asg ? run_en_on : 1'b1;
  wire panel_level = panel_asg ? panel_on :
    (opmode == OPMODE_INTERLOCK && !op_enabled);

  wire multi_on = !remote_mode && (sp_low | sp_mid | sp_high | sp_ext);
  wire [1:0] next_src = jog_on ? SRC_JOG :
    multi_on ? SRC_MULTI :
    pid_on ? SRC_PID : SRC_ANALOG;
  wire [3:0] next_index = remote_mode ? 4'h0 :
    {sp_ext, sp_high, sp_mid, sp_low};
  wire [2:0] next_remote = remote_mode ?
    {sp_high, sp_mid, sp_low} : 3'h0;

  wire next_vf = motor_running ? vf_control : ctrl_sw_on;
  wire next_second = second_on | ctrl_sw_on | next_vf;

  // Drive sequencing: shutoff forces coast from any running state.
  always_comb begin
    next_drv = drv;
    unique case (drv)
      DRV_STOP: begin
        if (start_cmd && run_permit && !shutoff_active) begin
          next_drv = DRV_RUN;
        end
      end
      DRV_RUN: begin
        if (shutoff_active || !run_permit) begin
          next_drv = DRV_COAST;
        end else if (!start_cmd) begin
          next_drv = DRV_DECEL;
        end
      end
      DRV_DECEL: begin
        if (shutoff_active || !run_permit) begin
          next_drv = DRV_COAST;
        end else if (start_cmd) begin
          next_drv = DRV_RUN;
        end else if (!motor_running) begin
          next_drv = DRV_STOP;
        end
      end
      DRV_COAST: begin
        if (!shutoff_active && !motor_running) begin
          next_drv = DRV_STOP;
        end
      end
    endcase
  end

  wire next_on = next_drv == DRV_RUN || next_drv == DRV_DECEL;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      drv <= DRV_STOP;
      output_on <= 1'b0;
      coast_out <= 1'b0;
      decel_out <= 1'b0;
    end else begin
      drv <= next_drv;
      output_on <= next_on;
      coast_out <= next_drv == DRV_COAST;
      decel_out <= next_drv == DRV_DECEL;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      vf_control <= 1'b0;
      second_set_select <= 1'b0;
      voltage_input_valid <= 1'b1;
      speed_src <= SRC_ANALOG;
      speed_index <= 4'h0;
      remote_cmd <= 3'h0;
      run_enable_ok <= 1'b0;
      panel_interlock_in <= 1'b0;
    end else begin
      vf_control <= next_vf;
      second_set_select <= next_second;
      voltage_input_valid <= !analog_on;
      speed_src <= its_speed_src_t'(next_src);
      speed_index <= next_index;
      remote_cmd <= next_remote;
      run_enable_ok <= run_permit;
      panel_interlock_in <= panel_level;
    end
  end

  // Register read data is captured in the address phase.
  wire [31:0] status_word = {21'h0, term_fast, speed_src, vf_control,
                             second_set_select, shutoff_active, output_on};
  wire term_hit = ap_addr < OFF_POLARITY && ap_addr[1:0] == 2'h0;
  wire [15:0] fn_sel = term_fn[ap_addr[4:2] < 3'(NUM_TERM) ?
                               ap_addr[4:2] : 3'h0];
  wire [31:0] rd_word =
    term_hit ? {16'h0, fn_sel} :
    ap_addr == OFF_POLARITY ? {29'h0, polarity} :
    ap_addr == OFF_OPMODE ? {24'h0, opmode} :
    ap_addr == OFF_CONTROL ? {30'h0, control} :
    ap_addr == OFF_STATUS ? status_word : 32'h0;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      hrdata <= 32'h0;
    end else if (ap_read) begin
      hrdata <= (haddr[31:8] == '0) ? rd_word : 32'h0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_shutoff_cuts_output: assert property (
    shutoff_active |=> !output_on)
    else $error("Output stayed on after shutoff.");

  a_shutoff_coasts_motor: assert property (
    shutoff_active && output_on |=> coast_out && !decel_out)
    else $error("Shutoff did not coast the motor.");

  a_start_blocked_shutoff: assert property (
    shutoff_active && start_cmd ##1 shutoff_active |=> !output_on)
    else $error("Start command overrode shutoff.");

  a_start_removal_decel: assert property (
    output_on && !start_cmd && !shutoff_active && run_permit
      && drv == DRV_RUN |=> decel_out && output_on)
    else $error("Start removal did not decelerate.");

  a_polarity_nc_pair: assert property (
    polarity == POL_NC |-> (shutoff_active == !(ext_shutoff && comm_shutoff)))
    else $error("Normally closed polarity decoded wrongly.");

  a_polarity_mixed: assert property (
    polarity == POL_MIX && ext_shutoff && !comm_shutoff |-> !shutoff_active)
    else $error("Mixed polarity did not enable operation.");

  a_polarity_open: assert property (
    polarity == POL_NO && (ext_shutoff || comm_shutoff) |-> shutoff_active)
    else $error("Normally open polarity missed a shutoff.");

  a_jog_priority: assert property (
    jog_on |=> speed_src == SRC_JOG)
    else $error("Jog lost speed priority.");

  a_multi_over_pid: assert property (
    !jog_on && multi_on && pid_on |=> speed_src == SRC_MULTI)
    else $error("PID took priority over multi-speed.");

  a_second_set_follow: assert property (
    second_on |=> second_set_select)
    else $error("Second set not selected.");

  a_vf_with_second: assert property (
    vf_control |-> second_set_select)
    else $error("V/F active without second set.");

  a_vf_frozen_run: assert property (
    motor_running |=> $stable(vf_control))
    else $error("Control method changed while running.");

  a_analog_invalid: assert property (
    analog_on |=> !voltage_input_valid)
    else $error("Voltage input still valid under analog select.");

  a_fast_pin_path: assert property (
    $rose(term_in[0]) && term_fn[0] == FN_SHUTOFF ##1
      term_fn[0] == FN_SHUTOFF [*2] |-> term_fast[0])
    else $error("Shutoff terminal slower than two edges.");

  a_run_enable_cut: assert property (
    !run_permit |=> !output_on)
    else $error("Output stayed on without run enable.");

  a_remote_no_index: assert property (
    remote_mode |=> speed_index == 4'h0)
    else $error("Multi-speed index active in remote mode.");

  a_interlock_shared: assert property (
    !panel_asg && opmode == OPMODE_INTERLOCK && shutoff_active
      |=> panel_interlock_in)
    else $error("Shutoff did not stand in for the interlock.");

  a_polarity_legal: assert property (
    polarity == POL_NO || polarity == POL_NC || polarity == POL_MIX)
    else $error("Polarity setting holds an illegal value.");

  a_switch_second_set: assert property (
    ctrl_sw_on |=> second_set_select)
    else $error("Control switch did not select the second set.");

endmodule

// >>> verif/its_contacts.sv
// Terminal contact model with optional one-cycle contact bounce.
`timescale 1ns/1ps
module its_contacts (
  input wire logic clk,
  input wire logic bounce,
  input wire logic [4:0] target,
  output logic [4:0] term_in
);
  logic [4:0] last;
  logic [4:0] prev;
  logic [1:0] phase;
  initial begin
    term_in = 5'h00;
    last = 5'h00;
    prev = 5'h00;
    phase = 2'h0;
  end
  // With bounce set, a changed contact takes its new level, springs back for one cycle, then settles.
  always @(posedge clk) begin
    if (target !== last) begin
      term_in <= target;
      prev <= last;
      last <= target;
      phase <= bounce ? 2'h2 : 2'h0;
    end else if (phase == 2'h2) begin
      term_in <= prev;
      phase <= 2'h1;
    end else if (phase == 2'h1) begin
      term_in <= last;
      phase <= 2'h0;
    end
  end
endmodule

// >>> verif/its_shutoff_logic_tb.sv
// Self-checking testbench for the input terminal shutoff logic.
`timescale 1ns/1ps
module its_shutoff_logic_tb;
  import its_pkg::*;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] hsize = 3'h0;
  logic start_cmd = 1'b0;
  logic motor_running = 1'b0;
  logic bounce = 1'b0;
  logic [4:0] target = 5'h00;
  logic [4:0] term_in;
  logic [31:0] hrdata;
  logic hreadyout, hresp, output_on, coast_out, decel_out;
  logic second_set_select, vf_control, voltage_input_valid;
  logic run_enable_ok, panel_interlock_in;
  its_speed_src_t speed_src;
  logic [3:0] speed_index;
  logic [2:0] remote_cmd;
  logic [31:0] r;
  logic [4:0] v;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #12.5 clk = ~clk;

  its_contacts contacts (.clk(clk), .bounce(bounce), .target(target),
    .term_in(term_in));

  its_shutoff_logic #(.SLOW_FILTER(4)) uut (.clk(clk), .nrst(nrst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .term_in(term_in),
    .start_cmd(start_cmd), .motor_running(motor_running),
    .output_on(output_on), .coast_out(coast_out), .decel_out(decel_out),
    .second_set_select(second_set_select), .vf_control(vf_control),
    .voltage_input_valid(voltage_input_valid), .speed_src(speed_src),
    .speed_index(speed_index), .remote_cmd(remote_cmd),
    .run_enable_ok(run_enable_ok), .panel_interlock_in(panel_interlock_in));

  task automatic complete_run();
    $display("Comparisons %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One single AHB-Lite transfer; called just after a rising edge.
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    ahb(1'b0, a, 32'h0, q);
  endtask

  task automatic pins(input logic [4:0] p, input logic b);
    bounce <= b;
    target <= p;
    cyc(16);
  endtask

  function automatic logic en(input int pol, input logic e, input logic c);
    if (pol == 0) return !e && !c;
    if (pol == 2) return e && c;
    return e && !c;
  endfunction

  function automatic its_speed_src_t exp_src(input logic j, m, p);
    if (j) return SRC_JOG;
    if (m) return SRC_MULTI;
    if (p) return SRC_PID;
    return SRC_ANALOG;
  endfunction

  initial begin
    void'($urandom(32'h56270cc4));
    cyc(8);
    nrst <= 1'b1;
    cyc(2);
    chk(output_on, 1'b0);
    chk(voltage_input_valid, 1'b1);
    chk(hresp, 1'b0);
    for (int i = 0; i < NUM_TERM; i++) begin
      rd(8'(i * 4), r);
      chk(r, {16'h0, TERM_FN_RST[i]});
    end
    rd(OFF_POLARITY, r);
    chk(r, 32'h0);
    wr(8'h24, 32'h5);
    rd(8'h24, r);
    chk(r, 32'h0);
    wr(OFF_TERM_FN, 32'h18);
    rd(OFF_TERM_FN, r);
    chk(r, 32'h18);
    start_cmd <= 1'b1;
    for (int p = 0; p < 3; p++) begin
      for (int k = 0; k < 4; k++) begin
        wr(OFF_POLARITY, 32'(p * 2));
        wr(OFF_CONTROL, {30'h0, k[1], 1'b0});
        pins({4'h0, k[0]}, 1'b0);
        cyc(4);
        chk(output_on, en(p * 2, k[0], k[1]));
      end
    end
    wr(OFF_POLARITY, 32'h3);
    wr(OFF_POLARITY, 32'h8);
    rd(OFF_POLARITY, r);
    chk(r, 32'h4);
    wr(OFF_POLARITY, 32'h0);
    wr(OFF_CONTROL, 32'h0);
    pins(5'h00, 1'b0);
    motor_running <= 1'b1;
    cyc(4);
    chk(output_on, 1'b1);
    target <= 5'h01;
    cyc(6);
    chk(output_on, 1'b0);
    chk(coast_out, 1'b1);
    target <= 5'h00;
    motor_running <= 1'b0;
    cyc(20);
    chk(output_on, 1'b1);
    motor_running <= 1'b1;
    start_cmd <= 1'b0;
    cyc(4);
    chk(decel_out, 1'b1);
    chk(coast_out, 1'b0);
    motor_running <= 1'b0;
    wr(OFF_TERM_FN + 8'h4, 32'ha);
    start_cmd <= 1'b1;
    pins(5'h02, 1'b0);
    chk(run_enable_ok, 1'b1);
    motor_running <= 1'b1;
    target <= 5'h00;
    cyc(6);
    chk(output_on, 1'b0);
    chk(run_enable_ok, 1'b0);
    motor_running <= 1'b0;
    wr(OFF_TERM_FN + 8'h4, 32'h3d);
    wr(OFF_OPMODE, 32'h7);
    wr(OFF_CONTROL, 32'h2);
    cyc(4);
    chk(panel_interlock_in, 1'b1);
    chk(output_on, 1'b0);
    wr(OFF_CONTROL, 32'h0);
    cyc(4);
    chk(panel_interlock_in, 1'b0);
    wr(OFF_OPMODE, 32'h0);
    start_cmd <= 1'b0;
    wr(OFF_TERM_FN, 32'h5);
    wr(OFF_TERM_FN + 8'h4, 32'he);
    wr(OFF_TERM_FN + 8'hc, 32'h3);
    wr(OFF_TERM_FN + 8'h10, 32'h3);
    for (int n = 0; n < 16; n++) begin
      v = 5'($urandom);
      pins(v, 1'b1);
      chk(speed_src, exp_src(v[0], v[2], v[1]));
      chk(speed_index, {3'h0, v[2]});
      chk(second_set_select, v[3] | v[4]);
      rd(OFF_STATUS, r);
      chk(r[10:6], v);
    end
    wr(OFF_TERM_FN + 8'hc, 32'h1);
    wr(OFF_TERM_FN + 8'h10, 32'h2);
    for (int n = 0; n < 8; n++) begin
      v = 5'($urandom);
      wr(OFF_CONTROL, {31'h0, n[0]});
      pins(v, 1'b1);
      chk(speed_index, n[0] ? 4'h0 : {1'b0, v[4:2]});
      chk(remote_cmd, n[0] ? v[4:2] : 3'h0);
    end
    wr(OFF_CONTROL, 32'h0);
    wr(OFF_TERM_FN + 8'hc, 32'h12);
    wr(OFF_TERM_FN + 8'h10, 32'h4);
    pins(5'h08, 1'b0);
    chk(vf_control, 1'b1);
    chk(second_set_select, 1'b1);
    pins(5'h00, 1'b0);
    motor_running <= 1'b1;
    pins(5'h08, 1'b0);
    chk(vf_control, 1'b0);
    chk(second_set_select, 1'b1);
    pins(5'h18, 1'b0);
    chk(voltage_input_valid, 1'b0);
    complete_run();
  end
endmodule
